// ### inc/i2c_regs_pkg.sv
// constants and types for the two-wire controller register block
package i2c_regs_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_FIFO = 8'h10;
   localparam logic [7:0] OFF_STD_HIGH = 8'h14;
   localparam logic [7:0] OFF_STD_LOW = 8'h18;
   localparam logic [7:0] OFF_FAST_HIGH = 8'h1c;
   localparam logic [7:0] OFF_FAST_LOW = 8'h20;
   localparam logic [7:0] OFF_HS_HIGH = 8'h24;
   localparam logic [7:0] OFF_HS_LOW = 8'h28;
   localparam logic [7:0] OFF_FLAGS = 8'h2c;
   localparam logic [7:0] OFF_MASK = 8'h30;
   localparam logic [7:0] OFF_RAW = 8'h34;
   localparam logic [7:0] OFF_RX_THRESHOLD_LEVEL = 8'h38;
   localparam logic [7:0] OFF_TX_TL = 8'h3c;
   localparam logic [7:0] OFF_CLR_ALL = 8'h40;
   localparam logic [7:0] OFF_ABORT = 8'h80;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_CMD = 8;
   localparam int BIT_STOP = 9;
   localparam int BIT_RESTART = 10;
   localparam int FL_RX_UNDER = 0;
   localparam int FL_RX_OVER = 1;
   localparam int FL_RX_FULL = 2;
   localparam int FL_TX_OVER = 3;
   localparam int FL_TX_EMPTY = 4;
   localparam int FL_RD_REQ = 5;
   localparam int FL_TX_ABORT = 6;
   localparam int FL_SLAVE_NACK = 7;
   localparam int FL_ACTIVITY = 8;
   localparam int FL_STOP = 9;
   localparam int FL_START = 10;
   localparam int FL_GEN_CALL = 11;
   localparam int FLAG_COUNT = 12;
   // ----------------------------------------------------------------
   // reset values and bus answers
   // ----------------------------------------------------------------
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [11:0] MASK_RESET = 12'h8ff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic restart;
      logic stop;
      logic write;
      logic [7:0] byteValue;
   } tx_cmd_type;
   typedef struct packed {
      logic [15:0] stdHigh;
      logic [15:0] stdLow;
      logic [15:0] fastHigh;
      logic [15:0] fastLow;
      logic [15:0] hsHigh;
      logic [15:0] hsLow;
   } scl_timing_type;
   typedef enum logic {LINK_IDLE, LINK_BUSY} link_state_type;
endpackage

// ### core/i2c_timing_regs.sv
// register block of the two-wire controller: queues, scl counts, interrupt flags
//
// Functional notes
// - fifo port bit 8 written: 0 asks a read transfer, 1 a write transfer.
// - fifo port bits 7:0 carry byte to send, read back received byte; reset zero.
// - offset 0x14 holds 16-bit standard-speed scl high count.
// - offset 0x18 holds 16-bit standard-speed scl low count.
// - offset 0x1c holds 16-bit fast-speed scl high count.
// - offset 0x20 holds 16-bit fast-speed scl low count.
// - offset 0x24 holds 16-bit high-speed scl high count.
// - offset 0x28 holds 16-bit high-speed scl low count.
// - bit 11 set when broadcast call received and acknowledged.
// - bit 10 set on start or repeated start seen on the bus.
// - bit 9 set on stop seen on the bus.
// - bit 8 records activity and stays until software clears it.
// - bit 7 set when master does not acknowledge our slave-sent byte.
// - bit 6 set when transmitter cannot complete queued actions.
// - bit 5 set when addressed as slave and a master reads us.
// - bit 4 high while transmit fill level at or below threshold.
// - bit 3 set when command written to full transmit queue.
// - bit 2 high while receive fill level at or above threshold.
// - bit 1 set when byte arrives at full receive queue.
// - bit 0 set when fifo port read with empty receive queue.
// - mask at 0x30, one bit per flag; resets to 0x8ff.
// - fifo port bit 9 written 1 requests stop after the byte.
// - fifo port bit 10 written 1 requests repeated start before the byte.
// - reading 0x40 clears every sticky flag and the abort record; level bits 4 and 2 can still hold irq.
`timescale 1ns/10ps
module i2c_timing_regs
   import i2c_regs_pkg::*;
#(
   parameter int TX_DEPTH = 8,
   parameter int RX_DEPTH = 8
)(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // axi4-lite slave
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // bus pins, sampled
   input wire logic sclIn,
   input wire logic sdaIn,
   // serial engine side
   output tx_cmd_type txCmd,
   output logic txValid,
   input wire logic txTake,
   input wire logic [7:0] rxByte,
   input wire logic rxValid,
   input wire logic genCallAck,
   input wire logic slaveNack,
   input wire logic txAbort,
   input wire logic [7:0] abortReason,
   input wire logic readRequest,
   output scl_timing_type sclTiming,
   // interrupt
   output logic irq
);
   localparam int TXW = $clog2(TX_DEPTH);
   localparam int RXW = $clog2(RX_DEPTH);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] mergeStrobe(input logic [31:0] old, input logic [31:0] val,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[8*i +: 8] = val[8*i +: 8];
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // axi write channels
   // ----------------------------------------------------------------
   logic awHeld_r, wHeld_r, bvalid_r, rvalid_r;
   logic [7:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic wrFire, rdFire, wrMapped, rdMapped;
   logic [31:0] wrValue;

   assign awready = !awHeld_r;
   assign wready = !wHeld_r;
   assign wrFire = awHeld_r && wHeld_r && !bvalid_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;

   always_ff @(posedge mclk)
   begin
      if (reset)
         awHeld_r <= 1'b0;
      else if (awvalid && awready)
         awHeld_r <= 1'b1;
      else if (wrFire)
         awHeld_r <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         awAddr_r <= 8'h00;
      else if (awvalid && awready)
         awAddr_r <= awaddr;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         wHeld_r <= 1'b0;
      else if (wvalid && wready)
         wHeld_r <= 1'b1;
      else if (wrFire)
         wHeld_r <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
      end
      else if (wvalid && wready)
      begin
         wData_r <= wdata;
         wStrb_r <= wstrb;
      end
   end

   always_comb
   begin
      case (awAddr_r)
         OFF_FIFO, OFF_STD_HIGH, OFF_STD_LOW, OFF_FAST_HIGH, OFF_FAST_LOW, OFF_HS_HIGH,
         OFF_HS_LOW, OFF_MASK, OFF_RX_THRESHOLD_LEVEL, OFF_TX_TL: wrMapped = 1'b1;
         default: wrMapped = 1'b0;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else if (wrFire)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
         bvalid_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   scl_timing_type timing_r;
   logic [11:0] mask_r;
   logic [7:0] rxTl_r, txTl_r;

   assign sclTiming = timing_r;

   function automatic logic [15:0] countWrite(input logic [15:0] old, input logic [31:0] val,
                                              input logic [3:0] strb);
      logic [31:0] m;
      m = mergeStrobe({16'h0000, old}, val, strb);
      return m[15:0];
   endfunction

   always_ff @(posedge mclk)
   begin
      if (reset)
         timing_r <= {6{COUNT_RESET}};
      else if (wrFire)
      begin
         if (awAddr_r == OFF_STD_HIGH)
            timing_r.stdHigh <= countWrite(timing_r.stdHigh, wData_r, wStrb_r);
         if (awAddr_r == OFF_STD_LOW)
            timing_r.stdLow <= countWrite(timing_r.stdLow, wData_r, wStrb_r);
         if (awAddr_r == OFF_FAST_HIGH)
            timing_r.fastHigh <= countWrite(timing_r.fastHigh, wData_r, wStrb_r);
         if (awAddr_r == OFF_FAST_LOW)
            timing_r.fastLow <= countWrite(timing_r.fastLow, wData_r, wStrb_r);
         if (awAddr_r == OFF_HS_HIGH)
            timing_r.hsHigh <= countWrite(timing_r.hsHigh, wData_r, wStrb_r);
         if (awAddr_r == OFF_HS_LOW)
            timing_r.hsLow <= countWrite(timing_r.hsLow, wData_r, wStrb_r);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         mask_r <= MASK_RESET;
         rxTl_r <= BYTE_RESET;
         txTl_r <= BYTE_RESET;
      end
      else if (wrFire)
      begin
         if (awAddr_r == OFF_MASK)
            mask_r <= 12'(mergeStrobe({20'h00000, mask_r}, wData_r, wStrb_r));
         if (awAddr_r == OFF_RX_THRESHOLD_LEVEL)
            rxTl_r <= 8'(mergeStrobe({24'h000000, rxTl_r}, wData_r, wStrb_r));
         if (awAddr_r == OFF_TX_TL)
            txTl_r <= 8'(mergeStrobe({24'h000000, txTl_r}, wData_r, wStrb_r));
      end
   end

   // ----------------------------------------------------------------
   // transmit queue
   // ----------------------------------------------------------------
   tx_cmd_type txMem [TX_DEPTH];
   logic [TXW:0] txWr_r, txRd_r, txCount;
   logic fifoWrite, txFull, txPush, txPop;

   assign wrValue = mergeStrobe(32'h0000_0000, wData_r, wStrb_r);
   assign fifoWrite = wrFire && (awAddr_r == OFF_FIFO);
   assign txCount = txWr_r - txRd_r;
   assign txFull = (txCount == (TXW+1)'(TX_DEPTH));
   assign txPush = fifoWrite && !txFull;
   assign txValid = (txCount != '0);
   assign txPop = txValid && txTake;
   assign txCmd = txMem[txRd_r[TXW-1:0]];

   always_ff @(posedge mclk)
   begin
      if (txPush)
      begin
         txMem[txWr_r[TXW-1:0]].write <= wrValue[BIT_CMD];
         txMem[txWr_r[TXW-1:0]].stop <= wrValue[BIT_STOP];
         txMem[txWr_r[TXW-1:0]].restart <= wrValue[BIT_RESTART];
         txMem[txWr_r[TXW-1:0]].byteValue <= wrValue[7:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         txWr_r <= '0;
         txRd_r <= '0;
      end
      else
      begin
         if (txPush)
            txWr_r <= txWr_r + 1'b1;
         if (txPop)
            txRd_r <= txRd_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // receive queue
   // ----------------------------------------------------------------
   logic [7:0] rxMem [RX_DEPTH];
   logic [RXW:0] rxWr_r, rxRd_r, rxCount;
   logic fifoRead, rxFull, rxEmpty, rxPush, rxPop, clearAll;

   assign fifoRead = rdFire && (araddr == OFF_FIFO);
   assign clearAll = rdFire && (araddr == OFF_CLR_ALL);
   assign rxCount = rxWr_r - rxRd_r;
   assign rxFull = (rxCount == (RXW+1)'(RX_DEPTH));
   assign rxEmpty = (rxCount == '0);
   assign rxPush = rxValid && !rxFull;
   assign rxPop = fifoRead && !rxEmpty;

   always_ff @(posedge mclk)
   begin
      if (rxPush)
         rxMem[rxWr_r[RXW-1:0]] <= rxByte;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         rxWr_r <= '0;
         rxRd_r <= '0;
      end
      else
      begin
         if (rxPush)
            rxWr_r <= rxWr_r + 1'b1;
         if (rxPop)
            rxRd_r <= rxRd_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // bus pin monitor
   // ----------------------------------------------------------------
   logic sclS1_r, sclS2_r, sclD_r, sdaS1_r, sdaS2_r, sdaD_r;
   logic startEv, stopEv;
   link_state_type link_r;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         {sclS1_r, sclS2_r, sclD_r} <= 3'h7;
         {sdaS1_r, sdaS2_r, sdaD_r} <= 3'h7;
      end
      else
      begin
         {sclS1_r, sclS2_r, sclD_r} <= {sclIn, sclS1_r, sclS2_r};
         {sdaS1_r, sdaS2_r, sdaD_r} <= {sdaIn, sdaS1_r, sdaS2_r};
      end
   end

   // sda edge while scl stays high
   assign startEv = sclS2_r && sclD_r && sdaD_r && !sdaS2_r;
   assign stopEv = sclS2_r && sclD_r && !sdaD_r && sdaS2_r;

   always_ff @(posedge mclk)
   begin
      if (reset)
         link_r <= LINK_IDLE;
      else
         case (link_r)
            LINK_IDLE: if (startEv) link_r <= LINK_BUSY;
            LINK_BUSY: if (stopEv) link_r <= LINK_IDLE;
            default: link_r <= LINK_IDLE;
         endcase
   end

   // ----------------------------------------------------------------
   // interrupt flags
   // ----------------------------------------------------------------
   logic [11:0] sticky_r, stickySet, rawView, flagView;
   logic [7:0] abort_r;

   always_comb
   begin
      stickySet = 12'h000;
      stickySet[FL_GEN_CALL] = genCallAck;
      stickySet[FL_START] = startEv;
      stickySet[FL_STOP] = stopEv;
      stickySet[FL_ACTIVITY] = (link_r == LINK_BUSY) || txPop || rxPush;
      stickySet[FL_SLAVE_NACK] = slaveNack;
      stickySet[FL_TX_ABORT] = txAbort;
      stickySet[FL_RD_REQ] = readRequest;
      stickySet[FL_TX_OVER] = fifoWrite && txFull;
      stickySet[FL_RX_OVER] = rxValid && rxFull;
      stickySet[FL_RX_UNDER] = fifoRead && rxEmpty;
   end

   // a new event in the clearing cycle survives
   always_ff @(posedge mclk)
   begin
      if (reset)
         sticky_r <= 12'h000;
      else
         sticky_r <= (clearAll ? 12'h000 : sticky_r) | stickySet;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         abort_r <= BYTE_RESET;
      else
         abort_r <= (clearAll ? BYTE_RESET : abort_r) | (txAbort ? abortReason : BYTE_RESET);
   end

   always_comb
   begin
      rawView = sticky_r;
      rawView[FL_TX_EMPTY] = (8'(txCount) <= txTl_r);
      rawView[FL_RX_FULL] = (8'(rxCount) >= rxTl_r);
   end

   assign flagView = rawView & mask_r;
   assign irq = |flagView;

   // ----------------------------------------------------------------
   // axi read channel
   // ----------------------------------------------------------------
   assign arready = !rvalid_r;
   assign rdFire = arvalid && arready;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   always_comb
   begin
      case (araddr)
         OFF_FIFO, OFF_STD_HIGH, OFF_STD_LOW, OFF_FAST_HIGH, OFF_FAST_LOW, OFF_HS_HIGH, OFF_HS_LOW,
         OFF_FLAGS, OFF_MASK, OFF_RAW, OFF_RX_THRESHOLD_LEVEL, OFF_TX_TL, OFF_CLR_ALL, OFF_ABORT: rdMapped = 1'b1;
         default: rdMapped = 1'b0;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end
      else if (rdFire)
      begin
         rvalid_r <= 1'b1;
         rresp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
         case (araddr)
            OFF_FIFO: rdata_r <= {24'h000000, rxEmpty ? BYTE_RESET : rxMem[rxRd_r[RXW-1:0]]};
            OFF_STD_HIGH: rdata_r <= {16'h0000, timing_r.stdHigh};
            OFF_STD_LOW: rdata_r <= {16'h0000, timing_r.stdLow};
            OFF_FAST_HIGH: rdata_r <= {16'h0000, timing_r.fastHigh};
            OFF_FAST_LOW: rdata_r <= {16'h0000, timing_r.fastLow};
            OFF_HS_HIGH: rdata_r <= {16'h0000, timing_r.hsHigh};
            OFF_HS_LOW: rdata_r <= {16'h0000, timing_r.hsLow};
            OFF_FLAGS: rdata_r <= {20'h00000, flagView};
            OFF_MASK: rdata_r <= {20'h00000, mask_r};
            OFF_RAW: rdata_r <= {20'h00000, rawView};
            OFF_RX_THRESHOLD_LEVEL: rdata_r <= {24'h000000, rxTl_r};
            OFF_TX_TL: rdata_r <= {24'h000000, txTl_r};
            OFF_ABORT: rdata_r <= {24'h000000, abort_r};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
      else if (rready)
         rvalid_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_start_flag: assert property (startEv |=> rawView[FL_START])
      else $error("start not flagged");
   a_stop_flag: assert property (stopEv |=> sticky_r[FL_STOP] ##1 sticky_r[FL_STOP] || $past(clearAll))
      else $error("stop not flagged");
   a_clear_all: assert property (clearAll && !genCallAck |=> !sticky_r[FL_GEN_CALL] && abort_r == 8'h00 ||
                                 $past(txAbort))
      else $error("clear-all left state");
   a_tx_over: assert property (fifoWrite && txFull |=> sticky_r[FL_TX_OVER] && $stable(txWr_r))
      else $error("overflow write mishandled");
   a_rx_under: assert property (fifoRead && rxEmpty |=> sticky_r[FL_RX_UNDER] && rdata_r[7:0] == 8'h00)
      else $error("underflow read mishandled");
   a_irq_gate: assert property (sticky_r[FL_START] && mask_r[FL_START] |-> irq)
      else $error("unmasked flag without irq");
   a_count_read: assert property (rdFire && araddr == OFF_STD_HIGH |=>
                                  rvalid && rdata == {16'h0000, $past(timing_r.stdHigh)})
      else $error("std high readback wrong");
   a_count_write: assert property (wrFire && awAddr_r == OFF_STD_LOW && wStrb_r == 4'hf |=>
                                   timing_r.stdLow == $past(wData_r[15:0]) && bvalid)
      else $error("std low write lost");
   a_cmd_bit: assert property (fifoWrite && txCount == '0 |=>
                               txValid && txCmd.write == $past(wData_r[BIT_CMD]))
      else $error("direction bit lost");

   c_start_stop: cover property (startEv ##[1:1000] stopEv);
   c_tx_over: cover property (fifoWrite && txFull);
   c_rx_under: cover property (fifoRead && rxEmpty);
   c_clear: cover property (irq ##1 clearAll ##1 !irq);
endmodule

// ### dv/i2c_engine_model.sv
// serial engine and bus pin model facing the register block
`timescale 1ns/10ps
module i2c_engine_model
   import i2c_regs_pkg::*;
(
   // clock
   input wire logic mclk,
   // transmit queue
   input tx_cmd_type txCmd,
   input wire logic txValid,
   output logic txTake,
   // receive and events
   output logic [7:0] rxByte,
   output logic rxValid,
   output logic [3:0] ev,
   output logic [7:0] abortReason,
   // pins
   output logic sclIn,
   output logic sdaIn
);
   logic stall = 1'b0;
   initial
   begin
      txTake = 1'b0;
      rxByte = 8'h00;
      rxValid = 1'b0;
      ev = 4'h0;
      abortReason = 8'h00;
      sclIn = 1'b1;
      sdaIn = 1'b1;
   end
   // pops at random pace unless held off
   always @(posedge mclk)
      txTake <= !stall && ($urandom_range(1) == 1);
   task automatic pushRx(input logic [7:0] b);
      @(posedge mclk);
      rxByte <= b;
      rxValid <= 1'b1;
      @(posedge mclk);
      rxValid <= 1'b0;
   endtask
   task automatic pulse(input int k);
      @(posedge mclk);
      ev <= 4'h1 << k;
      abortReason <= 8'($urandom);
      @(posedge mclk);
      ev <= 4'h0;
   endtask
   // link clock still outside the frame, 80 ns inside
   task automatic frame();
      sdaIn = 1'b0;
      for (int i = 0; i < 10; i++)
      begin
         #40 sclIn = 1'b0;
         #20 sdaIn = (i == 9) ? 1'b0 : 1'($urandom);
         #20 sclIn = 1'b1;
      end
      #40 sdaIn = 1'b1;
   endtask
endmodule

// ### dv/i2c_timing_regs_bench.sv
// self-checking bench for the two-wire register block
`timescale 1ns/10ps
module i2c_timing_regs_bench;
   import i2c_regs_pkg::*;
   localparam int DEPTH = 4;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, txValid, txTake, rxValid, irq, sclIn, sdaIn;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] rxByte, abortReason;
   logic [3:0] ev;
   tx_cmd_type txCmd;
   scl_timing_type sclTiming;
   logic [33:0] rdExp[$];
   logic [1:0] wrExp[$];
   tx_cmd_type txExp[$];
   int errors = 0, checks = 0, cycles = 0;
   int evBit[4] = '{FL_GEN_CALL, FL_SLAVE_NACK, FL_TX_ABORT, FL_RD_REQ};
   always #4 mclk = ~mclk;
   i2c_timing_regs #(.TX_DEPTH(DEPTH), .RX_DEPTH(DEPTH)) uut (.mclk(mclk), .reset(reset),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .sclIn(sclIn), .sdaIn(sdaIn), .txCmd(txCmd),
      .txValid(txValid), .txTake(txTake), .rxByte(rxByte), .rxValid(rxValid), .genCallAck(ev[0]),
      .slaveNack(ev[1]), .txAbort(ev[2]), .abortReason(abortReason), .readRequest(ev[3]),
      .sclTiming(sclTiming), .irq(irq));
   i2c_engine_model eng (.mclk(mclk), .txCmd(txCmd), .txValid(txValid), .txTake(txTake),
      .rxByte(rxByte), .rxValid(rxValid), .ev(ev), .abortReason(abortReason), .sclIn(sclIn),
      .sdaIn(sdaIn));
   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic compare(input string what, input logic [33:0] exp, input logic [33:0] got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // -------------------------------------------------------------
   // axi4-lite master, one transfer per call
   // -------------------------------------------------------------
   task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] exp);
      logic pa, pw, pb, ta, tw, tb;
      @(posedge mclk);
      pa = 1'b1;
      pw = wr;
      pb = 1'b1;
      if (wr)
         wrExp.push_back(exp[33:32]);
      else
         rdExp.push_back(exp);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= wr;
      wvalid <= wr;
      bready <= wr;
      arvalid <= !wr;
      rready <= !wr;
      while (pa | pw | pb)
      begin
         @(negedge mclk);
         ta = pa & (wr ? awready : arready);
         tw = pw & wready;
         tb = pb & !pa & !pw & (wr ? bvalid : rvalid);
         @(posedge mclk);
         if (ta)
            awvalid <= 1'b0;
         if (ta)
            arvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         if (tb)
            bready <= 1'b0;
         if (tb)
            rready <= 1'b0;
         pa = pa & !ta;
         pw = pw & !tw;
         pb = pb & !tb;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi(1'b1, a, d, {RESP_OKAY, 32'h0});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      axi(1'b0, a, 32'h0, {RESP_OKAY, e});
   endtask
   // -------------------------------------------------------------
   // output watcher
   // -------------------------------------------------------------
   always @(posedge mclk)
   begin
      cycles++;
      if (rvalid === 1'b1 && rready === 1'b1)
         compare("rdata", rdExp.pop_front(), {rresp, rdata});
      if (bvalid === 1'b1 && bready === 1'b1)
         compare("bresp", {32'h0, wrExp.pop_front()}, {32'h0, bresp});
      if (txValid === 1'b1 && txTake === 1'b1)
         compare("txCmd", {23'h0, txExp.pop_front()}, {23'h0, txCmd});
      if (cycles == 20000)
      begin
         errors++;
         conclude();
      end
   end
   initial
   begin
      tx_cmd_type c;
      logic [31:0] v;
      logic [7:0] b[DEPTH+1];
      int k;
      void'($urandom(32'h72cf));
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      for (k = 0; k < 6; k++)
         rd(OFF_STD_HIGH + 8'(4 * k), 32'h0);
      rd(OFF_MASK, 32'h8ff);
      rd(OFF_FLAGS, 32'h014);
      for (k = 0; k < 6; k++)
      begin
         v = $urandom;
         wr(OFF_STD_HIGH + 8'(4 * k), v);
         rd(OFF_STD_HIGH + 8'(4 * k), {16'h0, v[15:0]});
         compare("sclTiming", {18'h0, v[15:0]}, {18'h0, sclTiming[95 - 16 * k -: 16]});
      end
      // low byte lane only: upper byte of the count keeps its value
      wstrb <= 4'h1;
      wr(OFF_HS_LOW, 32'hffff_ffff);
      wstrb <= 4'hf;
      rd(OFF_HS_LOW, {16'h0, v[15:8], 8'hff});
      axi(1'b1, 8'h7c, v, {RESP_SLVERR, 32'h0});
      axi(1'b0, 8'h7c, 32'h0, {RESP_SLVERR, 32'h0});
      // transmit queue overrun with the engine held off
      wr(OFF_MASK, 32'hfff);
      eng.stall <= 1'b1;
      for (k = 0; k <= DEPTH; k++)
      begin
         c = 11'($urandom);
         if (k < DEPTH)
            txExp.push_back(c);
         wr(OFF_FIFO, {21'h0, c});
      end
      rd(OFF_FLAGS, 32'h00c);
      eng.stall <= 1'b0;
      for (k = 0; k < 300 && txValid !== 1'b0; k++)
         @(posedge mclk);
      rd(OFF_RAW, 32'h11c);
      rd(OFF_CLR_ALL, 32'h0);
      rd(OFF_RAW, 32'h014);
      // receive queue overrun, drain, underrun
      for (k = 0; k <= DEPTH; k++)
      begin
         b[k] = 8'($urandom);
         eng.pushRx(b[k]);
      end
      rd(OFF_RAW, 32'h116);
      for (k = 0; k < DEPTH; k++)
         rd(OFF_FIFO, {24'h0, b[k]});
      rd(OFF_FIFO, 32'h0);
      rd(OFF_RAW, 32'h117);
      rd(OFF_CLR_ALL, 32'h0);
      for (k = 0; k < 4; k++)
      begin
         eng.pulse(k);
         rd(OFF_RAW, 32'h014 | (32'h1 << evBit[k]));
         if (k == 2)
            rd(OFF_ABORT, {24'h0, abortReason});
         rd(OFF_CLR_ALL, 32'h0);
         rd(OFF_ABORT, 32'h0);
      end
      eng.frame();
      // let the stop pass the pin synchronisers before reading
      repeat (4) @(posedge mclk);
      rd(OFF_RAW, 32'h714);
      wr(OFF_MASK, 32'h200);
      rd(OFF_FLAGS, 32'h200);
      compare("irq", 34'h1, {33'h0, irq});
      wr(OFF_MASK, 32'h0);
      compare("irq", 34'h0, {33'h0, irq});
      conclude();
   end
endmodule
